// File: include/i2cea_pkg.sv
// Constants, types and a helper function for the I2C event and arbitration block
// What this block does
// - One interrupt request output, shared by every event source of the block.
// - Interrupt request follows the pending flag, gated by the interrupt enable bit.
// - Pending flag clears only when software writes one to it; zero leaves it.
// - Pending flag sets on byte done, address match or arbitration loss.
// - Byte done flag sets at the falling edge of the ninth clock.
// - Calling address equal to own address sets addressed flag and pending.
// - Losing arbitration sets the arbitration lost flag and the pending flag.
// - Lost when released data bit of address or data transmit reads low.
// - Lost when released acknowledge bit of controller receive reads low.
// - Lost when software requests a start while the bus is busy.
// - Lost when a repeated start is requested in target mode.
// - Lost when a stop appears that the controller did not request.
// - Arbitration lost flag stays set until software writes one to it.
// - Serial rate is bus clock over two times multiplier times divider.
// - First data byte after controller select is the address; bit zero is direction.
// - Controller transfer begins when software writes the data register, or in receive mode reads it.
// - Target joins a transaction only when the address equals its own address.
// - Each event keeps its own status flag so software can find the source.
// - Data write loads the byte to send; data read returns the last received.
// - Disabled after reset; no output can reset the surrounding system.
// - Losing controller releases data at once, becomes target, sends no stop.
package i2cea_pkg;
   localparam logic [7:0] ADDR_OWN = 8'h00;
   localparam logic [7:0] ADDR_FREQ = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] ADDR_DATA = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] OWN_RESET = 8'h00;
   localparam logic [7:0] FREQ_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Frequency divider layout: multiplier code in 7:6, divider index in 5:0
   localparam int FREQ_CLOCK_MULTIPLIER_FIELD_HI = 7;
   localparam int FREQ_CLOCK_MULTIPLIER_FIELD_LO = 6;
   localparam int FREQ_DIV_HI = 5;
   localparam logic [15:0] DIV_BASE = 16'h0014;
   localparam logic [3:0] BIT_LAST_DATA = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;

   typedef struct packed {
      logic module_enable_bit;
      logic interrupt_enable_bit;
      logic controller_select_bit;
      logic transmit_dir_bit;
      logic ack_suppress_bit;
      logic repeat_start_bit;
      logic [1:0] unused;
   } i2cea_ctrl_s;

   localparam i2cea_ctrl_s CTRL_RESET = '0;

   typedef struct packed {
      logic byte_done_flag;
      logic addressed_as_target_flag;
      logic bus_busy_flag;
      logic arbitration_lost_flag;
      logic unused;
      logic target_direction_flag;
      logic pending_flag;
      logic received_ack_flag;
   } i2cea_stat_s;

   localparam i2cea_stat_s STAT_RESET = '0;

   typedef enum logic [2:0] {
      C_IDLE = 3'b000,
      C_START = 3'b001,
      C_WAIT = 3'b010,
      C_LOW = 3'b011,
      C_HIGH = 3'b100,
      C_RESTART = 3'b101,
      C_STOP = 3'b110
   } i2cea_cstate_e;

   // Bus clocks per half serial period: multiplier times divider
   function automatic logic [15:0] i2cea_half_period(input logic [7:0] freq);
      logic [15:0] div;
      logic [1:0] code;
      div = DIV_BASE + {8'h00, freq[FREQ_DIV_HI:0], 2'b00};
      code = freq[FREQ_CLOCK_MULTIPLIER_FIELD_HI:FREQ_CLOCK_MULTIPLIER_FIELD_LO];
      case (code)
         2'h1: i2cea_half_period = {div[14:0], 1'b0};
         2'h2: i2cea_half_period = {div[13:0], 2'b00};
         default: i2cea_half_period = div;
      endcase
   endfunction : i2cea_half_period
endpackage : i2cea_pkg

// File: core/i2cea_top.sv
// I2C controller and target engine with status flags, arbitration and AXI4-Lite registers
`timescale 1ns/100ps
module i2cea_top
   import i2cea_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic irq
);
   logic aw_have, w_have, wr_go, wr_lane0;
   logic [7:0] aw_addr_q, w_data_q;
   logic wr_own, wr_freq, wr_ctrl, wr_stat, wr_data, rd_data, rd_go;
   logic [7:0] rd_value;
   logic [7:0] own_address_reg, frequency_divider_reg, shift_data_reg, tx_byte;
   i2cea_ctrl_s bus_control_reg, ctrl_wr;
   i2cea_stat_s stat;
   logic [2:0] scl_sync, sda_sync;
   logic scl_f, sda_f, scl_d, sda_d;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic en, rs_req, go_pend;
   i2cea_cstate_e c_state;
   logic [16:0] cnt, half_x, two_half, three_half;
   logic [3:0] c_bit, t_cnt;
   logic [7:0] c_shift, t_shift;
   logic c_scl, c_sda, c_first, c_lost, c_done, c_rx_done, c_ack_ev, c_ack_val, tx_mode;
   logic t_on, t_addr, t_sel, t_rw, t_ack, t_hold, t_nack, t_match, t_done, t_rx;
   logic t_ack_ev, t_sda_drv;
   logic arb_start_busy, arb_rs_target, arb_stop, arb_ev;

   assign en = bus_control_reg.module_enable_bit;
   assign ctrl_wr = i2cea_ctrl_s'(w_data_q);
   assign half_x = {1'b0, i2cea_half_period(frequency_divider_reg)};
   assign two_half = {half_x[15:0], 1'b0};
   assign three_half = two_half + half_x;
   assign tx_mode = c_first | bus_control_reg.transmit_dir_bit;

   // AXI4-Lite write path: address and data taken in either order
   assign wr_go = aw_have & w_have & ~s_axi_bvalid;
   assign wr_lane0 = wr_go & (aw_addr_q[1:0] == 2'b00);
   assign wr_own = wr_lane0 & (aw_addr_q == ADDR_OWN);
   assign wr_freq = wr_lane0 & (aw_addr_q == ADDR_FREQ);
   assign wr_ctrl = wr_lane0 & (aw_addr_q == ADDR_CTRL);
   assign wr_stat = wr_lane0 & (aw_addr_q == ADDR_STAT);
   assign wr_data = wr_lane0 & (aw_addr_q == ADDR_DATA);
   assign rd_go = s_axi_arvalid & s_axi_arready;
   assign rd_data = rd_go & (s_axi_araddr == ADDR_DATA);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 8'h00;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            // Only lane 0 carries a register; other lanes are ignored
            w_data_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
         if (s_axi_wvalid && s_axi_wready && !s_axi_wstrb[0]) begin
            s_axi_wready <= 1'b0;
         end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q <= ADDR_DATA && aw_addr_q[1:0] == 2'b00) ?
                           RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb begin
      case (s_axi_araddr)
         ADDR_OWN: rd_value = {own_address_reg[7:1], 1'b0};
         ADDR_FREQ: rd_value = frequency_divider_reg;
         ADDR_CTRL: rd_value = {bus_control_reg[7:3], 3'b000};
         ADDR_STAT: rd_value = stat;
         ADDR_DATA: rd_value = shift_data_reg;
         default: rd_value = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_value};
         s_axi_rresp <= (s_axi_araddr <= ADDR_DATA && s_axi_araddr[1:0] == 2'b00) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Plain configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         own_address_reg <= OWN_RESET;
         frequency_divider_reg <= FREQ_RESET;
         tx_byte <= DATA_RESET;
      end else begin
         if (wr_own) own_address_reg <= {w_data_q[7:1], 1'b0};
         if (wr_freq) frequency_divider_reg <= w_data_q;
         if (wr_data) tx_byte <= w_data_q;
      end
   end

   // Arbitration causes outside the bit engine: software requests and a foreign stop
   assign arb_start_busy = wr_ctrl & ctrl_wr.controller_select_bit &
                           ~bus_control_reg.controller_select_bit & stat.bus_busy_flag;
   assign arb_rs_target = wr_ctrl & ctrl_wr.repeat_start_bit &
                          ~bus_control_reg.controller_select_bit;
   assign arb_stop = stop_det & bus_control_reg.controller_select_bit &
                     (c_state != C_STOP);
   assign arb_ev = en & (arb_start_busy | arb_rs_target | arb_stop | c_lost);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_control_reg <= CTRL_RESET;
         rs_req <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            bus_control_reg <= {ctrl_wr[7:3], 3'b000};
            rs_req <= ctrl_wr.repeat_start_bit & bus_control_reg.controller_select_bit;
         end else if (c_state == C_RESTART || c_state == C_IDLE) begin
            rs_req <= 1'b0;
         end
         // Losing drops controller select at once; no stop is generated
         if (arb_ev) bus_control_reg.controller_select_bit <= 1'b0;
      end
   end

   // Status flags; a set in the same cycle as a clear wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat <= STAT_RESET;
      end else begin
         if (wr_stat && w_data_q[1]) stat.pending_flag <= 1'b0;
         if (wr_stat && w_data_q[4]) stat.arbitration_lost_flag <= 1'b0;
         if (wr_data || rd_data) stat.byte_done_flag <= 1'b0;
         if (wr_ctrl || stop_det) stat.addressed_as_target_flag <= 1'b0;
         if (start_det) stat.bus_busy_flag <= 1'b1;
         if (stop_det) stat.bus_busy_flag <= 1'b0;
         if (c_done || t_done) stat.byte_done_flag <= 1'b1;
         if (t_match) begin
            stat.addressed_as_target_flag <= 1'b1;
            stat.target_direction_flag <= t_rw;
         end
         if (c_ack_ev) stat.received_ack_flag <= c_ack_val;
         if (t_ack_ev) stat.received_ack_flag <= t_nack;
         if (arb_ev) stat.arbitration_lost_flag <= 1'b1;
         if (c_done || t_done || t_match || arb_ev) stat.pending_flag <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_data_reg <= DATA_RESET;
      end else if (c_rx_done) begin
         shift_data_reg <= c_shift;
      end else if (t_rx) begin
         shift_data_reg <= t_shift;
      end
   end

   // Pin synchronisers: a level counts once the second and third stages agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_i};
         sda_sync <= {sda_sync[1:0], sda_i};
         if (scl_sync[1] == scl_sync[2]) scl_f <= scl_sync[2];
         if (sda_sync[1] == sda_sync[2]) sda_f <= sda_sync[2];
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_d;
   assign scl_fall = ~scl_f & scl_d;
   assign start_det = scl_f & scl_d & sda_d & ~sda_f;
   assign stop_det = scl_f & scl_d & ~sda_d & sda_f;

   // Controller engine; drive flags mean pull the line low
   always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
         c_state <= C_IDLE;
         cnt <= 17'h0_0000;
         c_bit <= 4'h0;
         c_shift <= 8'h00;
         c_scl <= 1'b0;
         c_sda <= 1'b0;
         c_first <= 1'b0;
         c_lost <= 1'b0;
         c_done <= 1'b0;
         c_rx_done <= 1'b0;
         c_ack_ev <= 1'b0;
         c_ack_val <= 1'b0;
         go_pend <= 1'b0;
      end else begin
         c_lost <= 1'b0;
         c_done <= 1'b0;
         c_rx_done <= 1'b0;
         c_ack_ev <= 1'b0;
         case (c_state)
            C_IDLE: begin
               c_scl <= 1'b0;
               c_sda <= 1'b0;
               cnt <= 17'h0_0000;
               go_pend <= 1'b0;
               // A loss clears controller select one cycle late; no restart meanwhile
               if (bus_control_reg.controller_select_bit && !arb_ev) begin
                  c_state <= C_START;
                  c_sda <= 1'b1;
               end
            end
            C_START: begin
               cnt <= cnt + 17'h0_0001;
               if (cnt == half_x) begin
                  c_scl <= 1'b1;
                  c_first <= 1'b1;
                  c_state <= C_WAIT;
               end
            end
            C_WAIT: begin
               cnt <= 17'h0_0000;
               if (!bus_control_reg.controller_select_bit) begin
                  c_sda <= 1'b1;
                  c_state <= C_STOP;
               end else if (rs_req) begin
                  c_sda <= 1'b0;
                  c_state <= C_RESTART;
               end else if (go_pend) begin
                  go_pend <= 1'b0;
                  c_shift <= tx_byte;
                  c_bit <= 4'h0;
                  c_state <= C_LOW;
               end
            end
            C_LOW: begin
               cnt <= cnt + 17'h0_0001;
               if (cnt == 17'h0_0000) begin
                  if (c_bit == BIT_ACK) begin
                     c_sda <= ~tx_mode & ~bus_control_reg.ack_suppress_bit;
                  end else begin
                     c_sda <= tx_mode & ~c_shift[7];
                  end
               end
               if (cnt == half_x) begin
                  c_scl <= 1'b0;
                  cnt <= 17'h0_0000;
                  c_state <= C_HIGH;
               end
            end
            C_HIGH: begin
               // Counting waits while another party still holds the clock low
               if (scl_f) cnt <= cnt + 17'h0_0001;
               if (cnt == half_x || (cnt != 17'h0_0000 && !scl_f)) begin
                  cnt <= 17'h0_0000;
                  c_scl <= 1'b1;
                  c_state <= C_LOW;
                  if (!c_sda && !sda_f && ((c_bit == BIT_ACK) ? ~tx_mode : tx_mode)) begin
                     c_lost <= 1'b1;
                     c_scl <= 1'b0;
                     c_sda <= 1'b0;
                     c_state <= C_IDLE;
                  end else if (c_bit == BIT_ACK) begin
                     c_done <= 1'b1;
                     c_rx_done <= ~tx_mode;
                     c_ack_ev <= tx_mode;
                     c_ack_val <= sda_f;
                     c_first <= 1'b0;
                     c_state <= C_WAIT;
                  end else begin
                     c_shift <= {c_shift[6:0], sda_f};
                     c_bit <= c_bit + 4'h1;
                  end
               end
            end
            C_RESTART: begin
               cnt <= cnt + 17'h0_0001;
               if (cnt == half_x) c_scl <= 1'b0;
               if (cnt == two_half) c_sda <= 1'b1;
               if (cnt == three_half) begin
                  c_scl <= 1'b1;
                  c_first <= 1'b1;
                  c_state <= C_WAIT;
               end
            end
            C_STOP: begin
               cnt <= cnt + 17'h0_0001;
               if (cnt == half_x) c_scl <= 1'b0;
               if (cnt == two_half) begin
                  c_sda <= 1'b0;
                  c_state <= C_IDLE;
               end
            end
            default: c_state <= C_IDLE;
         endcase
         // Lost by a software cause or a foreign stop: let go of both lines
         if (arb_start_busy || arb_rs_target || arb_stop) begin
            c_scl <= 1'b0;
            c_sda <= 1'b0;
            c_state <= C_IDLE;
         end
         // Receive mode also advances on a read of the data register
         if (wr_data || (rd_data && !tx_mode)) go_pend <= 1'b1;
      end
   end

   // Target engine tracks every frame, so a lost address cycle can still match
   always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
         t_on <= 1'b0;
         t_addr <= 1'b0;
         t_sel <= 1'b0;
         t_rw <= 1'b0;
         t_ack <= 1'b0;
         t_hold <= 1'b0;
         t_nack <= 1'b0;
         t_cnt <= 4'h0;
         t_shift <= 8'h00;
         t_match <= 1'b0;
         t_done <= 1'b0;
         t_rx <= 1'b0;
         t_ack_ev <= 1'b0;
      end else begin
         t_match <= 1'b0;
         t_done <= 1'b0;
         t_rx <= 1'b0;
         t_ack_ev <= 1'b0;
         if (start_det) begin
            t_on <= 1'b1;
            t_addr <= 1'b1;
            t_sel <= 1'b0;
            t_ack <= 1'b0;
            t_hold <= 1'b0;
            t_nack <= 1'b0;
            t_cnt <= 4'hf; // Clock fall after a start is no bit
         end else if (stop_det) begin
            t_on <= 1'b0;
            t_sel <= 1'b0;
            t_ack <= 1'b0;
            t_hold <= 1'b0;
         end else begin
            if (t_hold && (wr_data || rd_data)) t_hold <= 1'b0;
            if (t_on && scl_rise && t_cnt <= BIT_LAST_DATA) t_shift <= {t_shift[6:0], sda_f};
            if (t_on && scl_rise && t_cnt == BIT_ACK && t_sel && t_rw && !t_addr) begin
               t_nack <= sda_f;
               t_ack_ev <= 1'b1;
            end
            if (t_on && scl_fall) begin
               if (t_cnt == BIT_LAST_DATA) begin
                  t_cnt <= BIT_ACK;
                  if (t_addr) begin
                     // Own transfers never select this target
                     if (t_shift[7:1] == own_address_reg[7:1] && c_state == C_IDLE) begin
                        t_sel <= 1'b1;
                        t_match <= 1'b1;
                        t_ack <= 1'b1;
                        t_rw <= t_shift[0];
                     end
                  end else if (t_sel && !t_rw) begin
                     t_rx <= 1'b1;
                     t_ack <= ~bus_control_reg.ack_suppress_bit;
                  end
               end else if (t_cnt == BIT_ACK) begin
                  t_cnt <= 4'h0;
                  t_ack <= 1'b0;
                  t_addr <= 1'b0;
                  if (t_sel) begin
                     t_done <= 1'b1;
                     t_hold <= 1'b1;
                  end
               end else begin
                  t_cnt <= t_cnt + 4'h1;
               end
            end
         end
      end
   end

   assign t_sda_drv = t_ack | (t_sel & t_rw & ~t_addr & ~t_nack & ~t_hold &
                      (t_cnt <= BIT_LAST_DATA) & ~tx_byte[3'(BIT_LAST_DATA - t_cnt)]);

   // Pin drivers and the single interrupt request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         irq <= 1'b0;
      end else begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe <= c_scl | t_hold;
         sda_oe <= c_sda | t_sda_drv;
         irq <= stat.pending_flag & bus_control_reg.interrupt_enable_bit;
      end
   end
endmodule : i2cea_top

// File: sim/i2cea_target_model.sv
// Behavioural bus target that acknowledges its own address
`timescale 1ns/100ps
module i2cea_target_model #(parameter logic [6:0] ADDR = 7'h52) (
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe
);
   int cnt = 0;
   logic [7:0] sh = '0;
   initial sda_oe = 1'b0;
   always @(negedge sda) if (scl) cnt = 0;
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
      cnt = cnt + 1;
   end
   // Only the first byte is judged; released otherwise, pull-up wins
   always @(negedge scl) sda_oe <= (cnt == 8) && (sh[7:1] == ADDR);
endmodule : i2cea_target_model

// File: sim/i2cea_top_asserts.sv
// Port checker for the event and arbitration block
`timescale 1ns/100ps
module i2cea_top_asserts
   import i2cea_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic sda_oe,
   input wire logic scl_oe,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   wire wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !sda_oe && !scl_oe)
      else $error("outputs busy after reset");
   a_write_answer: assert property (wt |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   a_ready_low: assert property (wt |=> !s_axi_awready && !s_axi_wready)
      else $error("second write accepted");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
      else $error("read answer wrong");
   a_pending_clear: assert property (wt && s_axi_awaddr == ADDR_STAT && s_axi_wdata[1]
      |-> ##3 !irq)
      else $error("pending not cleared");
   a_irq_masked: assert property (wt && s_axi_awaddr == ADDR_CTRL && !s_axi_wdata[6]
      |-> ##3 !irq)
      else $error("request not masked");
   a_disable_release: assert property (wt && s_axi_awaddr == ADDR_CTRL && !s_axi_wdata[7]
      |-> ##4 !sda_oe && !scl_oe)
      else $error("lines held when disabled");
   a_irq_stays: assert property (irq && !wt && !$past(wt) && !$past(wt, 2) |=> irq)
      else $error("request dropped without write");
endmodule : i2cea_top_asserts
bind i2cea_top i2cea_top_asserts u_chk (.*);

// File: sim/i2cea_bench.sv
// Self-checking bench for the event and arbitration block
`timescale 1ns/100ps
module i2cea_bench import i2cea_pkg::*;;
   logic aclk = 0, aresetn = 0, m_oe;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, v;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, scl_o, scl_oe, sda_o, sda_oe, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic x_scl = 0, x_sda = 0, s;
   wire scl_i = !(scl_oe || x_scl);
   wire sda_i = !(sda_oe || m_oe || x_sda);
   int fail_count = 0, n_compared = 0, seed = 79, cyc = 0;
   always #25 aclk = !aclk;
   i2cea_top dut (.*);
   i2cea_target_model tgt (.scl(scl_i), .sda(sda_i), .sda_oe(m_oe));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er, "bresp");
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h0, e}, "rdata");
      chk(s_axi_rresp, er, "rresp");
   endtask : rd
   task automatic wait_irq();
      int n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge aclk);
         n++;
      end
      chk(irq, 1, "irq");
   endtask : wait_irq
   // Foreign controller bit; data moves two cycles after the clock falls
   task automatic xbit(input logic b, output logic got);
      repeat (2) @(posedge aclk);
      x_sda <= !b;
      repeat (6) @(posedge aclk);
      x_scl <= 1'b0;
      repeat (8) @(posedge aclk);
      got = sda_i;
      x_scl <= 1'b1;
   endtask : xbit
   task automatic summarize();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      // Whole run needs under 3000 cycles
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (5) @(posedge aclk);
      rd(ADDR_STAT, 8'h00, RESP_OKAY);
      rd(ADDR_CTRL, 8'h00, RESP_OKAY);
      rd(8'h14, 8'h00, RESP_SLVERR);
      wr(8'h14, 8'h55, RESP_SLVERR);
      v = 8'($random(seed));
      wr(ADDR_OWN, v, RESP_OKAY);
      rd(ADDR_OWN, v & 8'hfe, RESP_OKAY);
      // A disabled block ignores requests, so enable first
      wr(ADDR_CTRL, 8'hc0, RESP_OKAY);
      // Repeat start while not controller
      wr(ADDR_CTRL, 8'hc4, RESP_OKAY);
      wait_irq();
      rd(ADDR_STAT, 8'h12, RESP_OKAY);
      wr(ADDR_STAT, 8'h00, RESP_OKAY);
      rd(ADDR_STAT, 8'h12, RESP_OKAY);
      wr(ADDR_STAT, 8'h10, RESP_OKAY);
      rd(ADDR_STAT, 8'h02, RESP_OKAY);
      wr(ADDR_CTRL, 8'h80, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(irq, 0, "irq");
      wr(ADDR_STAT, 8'h02, RESP_OKAY);
      wr(ADDR_FREQ, 8'h00, RESP_OKAY);
      wr(ADDR_CTRL, 8'hd0, RESP_OKAY);
      wr(ADDR_CTRL, 8'hf0, RESP_OKAY);
      repeat (600) @(posedge aclk);
      chk(irq, 0, "irq");
      wr(ADDR_DATA, {7'h52, 1'b0}, RESP_OKAY);
      wait_irq();
      rd(ADDR_STAT, 8'ha2, RESP_OKAY);
      wr(ADDR_STAT, 8'h02, RESP_OKAY);
      wr(ADDR_CTRL, 8'h00, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk({scl_oe, sda_oe, irq}, 0, "lines");
      // Target mode: a foreign controller calls the own address for a read
      wr(ADDR_CTRL, 8'hc0, RESP_OKAY);
      x_sda <= 1'b1;
      repeat (8) @(posedge aclk);
      x_scl <= 1'b1;
      for (int i = 7; i >= 0; i--) begin
         xbit(i ? v[i] : 1'b1, s);
      end
      xbit(1'b1, s);
      chk(s, 0, "ack");
      wait_irq();
      rd(ADDR_STAT, 8'he6, RESP_OKAY);
      wr(ADDR_CTRL, 8'hd0, RESP_OKAY);
      wr(ADDR_DATA, v, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(scl_oe, 0, "stretch");
      summarize();
   end
endmodule : i2cea_bench
